// file: design/telegram_start_sync_detector.sv
// Telegram-start pattern detector with AHB-Lite register slave.
// Assumes chip_valid pulses at most every second sys_clk cycle.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps

// What this block does
// - Two identical write-only setting sets at 0x82-0x89 and 0xa2-0xa9.
// - Mode bit 7 set: pulse bit-recovery PLL reset when the gap ends.
// - Mode bits 6:3 give tolerated chip errors for correlator A.
// - Mode bit 2 set: realign chip phase on every 1001 or 0110 while locked.
// - Mode 00: A then directly B; B used only if its length is nonzero.
// - Mode 01: A or B in parallel starts the frame.
// - Mode 10: A, then programmed gap, then B, in sequence.
// - Mode 11: A or B; leading data bit tells which one matched.
// - A length is 0 to 16 chips; larger codes are clamped.
// - A length zero only in mode 00, syncing on symbol sync alone.
// - B length is 0 to 16 chips; larger codes are clamped.
// - Gap bits 7:3 count half-bit chips of gap after pattern A.
// - Gap bits 2:0 fine offset corrects oscillator phase w/o resync.
// - Pattern A chips 7:0 from low byte, 15:8 from high byte.
module telegram_start_sync_detector
  import tsd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        chip_valid,
  input  wire logic        chip_data,
  input  wire logic        sym_sync,
  output logic             frame_sync_event,
  output logic             found_pattern_b,
  output logic             pll_reset,
  output logic             dco_phase_adjust,
  output logic [2:0]       dco_fine_offset,
  output logic             manchester_phase,
  output logic             phase_realigned,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Bus slave: address phase decode
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_idx;
  logic [7:0]  cfg [0:1][0:7];
  logic        ctrl_sel;
  logic [2:0]  status;
  logic [2:0]  mask;
  state_type   state;
  logic [4:0]  cnt;
  logic [15:0] hist;
  logic        tick;

  wire        acc     = hsel && htrans[1] && hready;
  wire        addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
  wire [7:0]  rd_idx  = haddr[9:2];

  // Configuration is write-only; own registers read back
  wire [31:0] rd_value =
    !addr_ok               ? 32'h0 :
    (rd_idx == IDX_CTRL)   ? {31'h0, ctrl_sel} :
    (rd_idx == IDX_STATUS) ? {29'h0, status} :
    (rd_idx == IDX_MASK)   ? {29'h0, mask} :
    (rd_idx == IDX_STATE)  ? {28'h0, found_pattern_b, manchester_phase,
                              state} :
    32'h0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= acc && hwrite && addr_ok;
      wr_idx    <= rd_idx;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: data phase write decode
  // ----------------------------------------------------------------
  wire [7:0] rel1    = wr_idx - IDX_MODE1;
  wire [7:0] rel2    = wr_idx - IDX_MODE2;
  wire       in1     = (wr_idx >= IDX_MODE1) && (wr_idx <= IDX_PBH1);
  wire       in2     = (wr_idx >= IDX_MODE2) && (wr_idx <= IDX_PBH2);
  wire       cfg_we  = wr_pend && (in1 || in2);
  wire       cfg_set = in2;
  wire [2:0] cfg_ent = in2 ? rel2[2:0] : rel1[2:0];
  wire       ctrl_we = wr_pend && (wr_idx == IDX_CTRL);
  wire       stat_we = wr_pend && (wr_idx == IDX_STATUS);
  wire       mask_we = wr_pend && (wr_idx == IDX_MASK);
  wire       restart = ctrl_we && (hwdata[CTRL_HUNT] ||
                       (hwdata[CTRL_SEL] != ctrl_sel));

  // Two full sets so software can retune one while the other runs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int s = 0; s < 2; s++) begin
        for (int e = 0; e < 8; e++) begin
          cfg[s][e] <= CFG_RESET;
        end
      end
    end else if (cfg_we) begin
      cfg[cfg_set][cfg_ent] <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_sel <= 1'b0;
      mask     <= EV_RESET;
    end else begin
      if (ctrl_we) begin
        ctrl_sel <= hwdata[CTRL_SEL];
      end
      if (mask_we) begin
        mask <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Active setting fields
  // ----------------------------------------------------------------
  wire [7:0] mode_r  = cfg[ctrl_sel][ENT_MODE];
  wire [7:0] lena_r  = cfg[ctrl_sel][ENT_LENA];
  wire [7:0] lenb_r  = cfg[ctrl_sel][ENT_LENB];
  wire [7:0] gap_r   = cfg[ctrl_sel][ENT_GAP];

  wire       gap_resync_enable        = mode_r[RESYNC_BIT];
  wire [3:0] correlator_a_wildcards   = mode_r[WILD_MSB:WILD_LSB];
  wire       manchester_phase_realign = mode_r[REALIGN_BIT];
  wire [1:0] mode_bits                = mode_r[DMODE_MSB:DMODE_LSB];
  detect_mode_type start_detect_mode;
  assign start_detect_mode = detect_mode_type'(mode_bits);

  wire [4:0] coarse_gap_time  = gap_r[COARSE_MSB:COARSE_LSB];
  wire [2:0] fine_gap_offset  = gap_r[FINE_MSB:0];

  // Unused length codes would read past the window
  wire [4:0] lena_raw = lena_r[LEN_MSB:0];
  wire [4:0] lenb_raw = lenb_r[LEN_MSB:0];
  wire [4:0] len_a    = (lena_raw > MAX_LEN) ? MAX_LEN : lena_raw;
  wire [4:0] len_b    = (lenb_raw > MAX_LEN) ? MAX_LEN : lenb_raw;

  wire [15:0] pattern_a = {cfg[ctrl_sel][ENT_PAH],
                           cfg[ctrl_sel][ENT_PAL]};
  wire [15:0] pattern_b = {cfg[ctrl_sel][ENT_PBH],
                           cfg[ctrl_sel][ENT_PBL]};

  // ----------------------------------------------------------------
  // Chip history and correlators
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hist <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= chip_valid;
      if (chip_valid) begin
        hist <= {hist[14:0], chip_data};
      end
    end
  end

  corr_if corr_a ();
  corr_if corr_b ();

  assign corr_a.pattern   = pattern_a;
  assign corr_a.length    = len_a;
  assign corr_a.wildcards = correlator_a_wildcards;
  assign corr_a.history   = hist;
  assign corr_b.pattern   = pattern_b;
  assign corr_b.length    = len_b;
  assign corr_b.wildcards = 4'h0;
  assign corr_b.history   = hist;

  window_correlator u_corr_a (
    .p (corr_a.corr)
  );

  window_correlator u_corr_b (
    .p (corr_b.corr)
  );

  // A zero length never counts as a hit in modes 01 and 11; in mode 10 a zero B length matches at once
  wire a_ok  = (len_a != 5'h00) && corr_a.match;
  wire b_ok  = (len_b != 5'h00) && corr_b.match;
  wire a_seq = (len_a == 5'h00) ? sym_sync : (tick && a_ok);
  wire pair  = (hist[3:0] == 4'b1001) || (hist[3:0] == 4'b0110);
  wire align = (state == LOCKED) && tick && manchester_phase_realign &&
               pair;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_type  next_state;
  logic [4:0] next_cnt;
  logic       sync_go;
  logic       found_b_go;
  logic       gap_go;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    sync_go    = 1'b0;
    found_b_go = 1'b0;
    gap_go     = 1'b0;
    unique case (state)
      HUNT: begin
        next_cnt = 5'h00;
        unique case (start_detect_mode)
          SEQ16: begin
            if (a_seq) begin
              if (len_b == 5'h00) begin
                sync_go = 1'b1;
              end else begin
                next_state = SEEK_B;
              end
            end
          end
          PAR8, EXT8: begin
            if (tick && (a_ok || b_ok)) begin
              sync_go    = 1'b1;
              found_b_go = !a_ok;
            end
          end
          GAP8: begin
            if (tick && a_ok) begin
              next_state = GAP;
            end
          end
        endcase
      end
      GAP: begin
        if (cnt == coarse_gap_time) begin
          gap_go     = 1'b1;
          next_state = SEEK_B;
          // With no gap, a chip taken here is already the first chip of B
          next_cnt   = {4'h0, chip_valid};
        end else if (chip_valid) begin
          next_cnt = cnt + 5'h01;
        end
      end
      SEEK_B: begin
        if (cnt == len_b) begin
          if (corr_b.match) begin
            sync_go = 1'b1;
          end else begin
            next_state = HUNT;
          end
        end else if (chip_valid) begin
          next_cnt = cnt + 5'h01;
        end
      end
      LOCKED: begin
        next_cnt = 5'h00;
      end
    endcase
    if (sync_go) begin
      next_state = LOCKED;
    end
    if (restart) begin
      next_state = HUNT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= HUNT;
      cnt   <= 5'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Link-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_sync_event <= 1'b0;
      found_pattern_b  <= 1'b0;
      pll_reset        <= 1'b0;
      dco_phase_adjust <= 1'b0;
      dco_fine_offset  <= 3'h0;
      phase_realigned  <= 1'b0;
    end else begin
      frame_sync_event <= sync_go;
      pll_reset        <= gap_go && gap_resync_enable;
      dco_phase_adjust <= gap_go && !gap_resync_enable;
      phase_realigned  <= align;
      if (sync_go) begin
        found_pattern_b <= found_b_go;
      end
      if (gap_go) begin
        dco_fine_offset <= fine_gap_offset;
      end
    end
  end

  // Phase names the half of the next chip: 0 first, 1 second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      manchester_phase <= 1'b0;
    end else if (sync_go || align) begin
      manchester_phase <= 1'b0;
    end else if ((state == LOCKED) && chip_valid) begin
      manchester_phase <= !manchester_phase;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  wire [2:0] ev;
  assign ev[EV_SYNC]  = sync_go;
  assign ev[EV_GAP]   = gap_go;
  assign ev[EV_ALIGN] = align;
  wire [2:0] clr         = stat_we ? hwdata[2:0] : 3'h0;
  wire [2:0] next_status = (status & ~clr) | ev;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status <= EV_RESET;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_cfg_write_lands: assert property (
    cfg_we && !cfg_set |=> cfg[0][$past(cfg_ent)] == $past(hwdata[7:0]))
    else $error("config write not stored");

  a_gap_pll_reset: assert property (
    gap_go && gap_resync_enable |=> pll_reset && !dco_phase_adjust)
    else $error("gap end without pll reset");

  a_fine_phase_fix: assert property (
    gap_go && !gap_resync_enable |=>
      dco_phase_adjust && dco_fine_offset == $past(fine_gap_offset))
    else $error("fine offset not applied");

  a_realign_phase: assert property (
    align |=> phase_realigned && !manchester_phase ##1 !phase_realigned)
    else $error("phase realign missing");

  a_par_either: assert property (
    state == HUNT && !restart && tick && start_detect_mode == PAR8 &&
      (a_ok || b_ok) |=> frame_sync_event && state == LOCKED)
    else $error("parallel match did not sync");

  a_ext_lead_bit: assert property (
    state == HUNT && tick && start_detect_mode == EXT8 && b_ok && !a_ok
      |=> frame_sync_event && found_pattern_b)
    else $error("leading bit does not name pattern b");

  a_gap_sequence: assert property (
    sync_go && start_detect_mode == GAP8 |-> state == SEEK_B)
    else $error("gap mode synced out of sequence");

  a_seq_b_used: assert property (
    sync_go && start_detect_mode == SEQ16 && len_b != 5'h00
      |-> state == SEEK_B && cnt == len_b)
    else $error("pattern b skipped in sequential mode");

  a_irq_level: assert property (
    |(status & mask) |=> irq || $past(stat_we))
    else $error("interrupt not raised");

endmodule // telegram_start_sync_detector

// file: design/window_correlator.sv
// Correlator of the newest chips against a reference pattern.
// Assumes history bit 0 is the newest chip; purely combinational.
`timescale 1ns/10ps
module window_correlator (
  corr_if.corr p
);
  logic [15:0] diff;
  logic [4:0]  errs;

  // ----------------------------------------------------------------
  // Per-chip compare, only inside the configured length
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_chip
    assign diff[i] = (5'(i) < p.length) &&
                     (p.history[i] != p.pattern[i]);
  end

  always_comb begin
    errs = 5'h00;
    for (int i = 0; i < 16; i++) begin
      errs = errs + {4'h0, diff[i]};
    end
  end

  // Wildcards count tolerated chip errors
  assign p.match = errs <= {1'b0, p.wildcards};
endmodule // window_correlator

// file: pkg/corr_if.sv
// Link between the detector core and one chip-window correlator.
// Assumes one driver per side, all signals combinational.
`timescale 1ns/10ps
interface corr_if;
  logic [15:0] pattern;
  logic [4:0]  length;
  logic [3:0]  wildcards;
  logic [15:0] history;
  logic        match;
  modport ctl  (output pattern, length, wildcards, history, input match);
  modport corr (input pattern, length, wildcards, history, output match);
endinterface // corr_if

// file: pkg/tsd_pkg.sv
// Constants, field layout and types of the telegram-start detector.
// Assumes a 32-bit AHB-Lite register port, word index = byte address / 4.
package tsd_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MODE1   = 8'h82;
  localparam logic [7:0] IDX_LENA1   = 8'h83;
  localparam logic [7:0] IDX_LENB1   = 8'h84;
  localparam logic [7:0] IDX_GAP1    = 8'h85;
  localparam logic [7:0] IDX_PAL1    = 8'h86;
  localparam logic [7:0] IDX_PAH1    = 8'h87;
  localparam logic [7:0] IDX_PBL1    = 8'h88;
  localparam logic [7:0] IDX_PBH1    = 8'h89;
  localparam logic [7:0] IDX_MODE2   = 8'ha2;
  localparam logic [7:0] IDX_LENA2   = 8'ha3;
  localparam logic [7:0] IDX_LENB2   = 8'ha4;
  localparam logic [7:0] IDX_GAP2    = 8'ha5;
  localparam logic [7:0] IDX_PAL2    = 8'ha6;
  localparam logic [7:0] IDX_PAH2    = 8'ha7;
  localparam logic [7:0] IDX_PBL2    = 8'ha8;
  localparam logic [7:0] IDX_PBH2    = 8'ha9;
  localparam logic [7:0] IDX_CTRL    = 8'hc0;
  localparam logic [7:0] IDX_STATUS  = 8'hc1;
  localparam logic [7:0] IDX_MASK    = 8'hc2;
  localparam logic [7:0] IDX_STATE   = 8'hc3;

  // ----------------------------------------------------------------
  // Entry numbers inside one configuration set
  // ----------------------------------------------------------------
  localparam logic [2:0] ENT_MODE    = 3'h0;
  localparam logic [2:0] ENT_LENA    = 3'h1;
  localparam logic [2:0] ENT_LENB    = 3'h2;
  localparam logic [2:0] ENT_GAP     = 3'h3;
  localparam logic [2:0] ENT_PAL     = 3'h4;
  localparam logic [2:0] ENT_PAH     = 3'h5;
  localparam logic [2:0] ENT_PBL     = 3'h6;
  localparam logic [2:0] ENT_PBH     = 3'h7;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         RESYNC_BIT  = 7;
  localparam int         WILD_MSB    = 6;
  localparam int         WILD_LSB    = 3;
  localparam int         REALIGN_BIT = 2;
  localparam int         DMODE_MSB   = 1;
  localparam int         DMODE_LSB   = 0;
  localparam int         LEN_MSB     = 4;
  localparam int         COARSE_MSB  = 7;
  localparam int         COARSE_LSB  = 3;
  localparam int         FINE_MSB    = 2;
  localparam int         CTRL_SEL    = 0;
  localparam int         CTRL_HUNT   = 1;
  localparam int         EV_SYNC     = 0;
  localparam int         EV_GAP      = 1;
  localparam int         EV_ALIGN    = 2;
  localparam logic [4:0] MAX_LEN     = 5'h10;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [2:0] EV_RESET    = 3'h0;

  typedef enum logic [1:0] {
    SEQ16 = 2'b00,
    PAR8  = 2'b01,
    GAP8  = 2'b10,
    EXT8  = 2'b11
  } detect_mode_type;

  typedef enum logic [1:0] {
    HUNT   = 2'b00,
    GAP    = 2'b01,
    SEEK_B = 2'b10,
    LOCKED = 2'b11
  } state_type;

endpackage

// file: tb/chip_source.sv
// Stand-in for the receiver slicer: source of demodulated chips.
// Assumes the detector takes a chip on each sys_clk edge with chip_valid.
`timescale 1ns/10ps
module chip_source (
  input  wire logic sys_clk,
  output logic      chip_valid,
  output logic      chip_data
);
  initial begin
    chip_valid = 1'b0;
    chip_data  = 1'b0;
  end

  // ------------------------------------------------------------
  // Chip stream, oldest chip first
  // ------------------------------------------------------------
  // Two cycles a chip is the densest spacing the detector takes;
  // slow adds idle cycles. The data line is not held between chips.
  task automatic send(input logic [31:0] s, input int n, input int slow);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      chip_valid <= 1'b1;
      chip_data  <= s[i];
      @(posedge sys_clk);
      chip_valid <= 1'b0;
      chip_data  <= ~s[i];
      repeat (slow) @(posedge sys_clk);
    end
  endtask
endmodule // chip_source

// file: tb/telegram_start_sync_detector_tb.sv
// Self-checking bench for the telegram-start detector.
// Assumes a zero-wait AHB-Lite slave and a slicer model for chips.
`timescale 1ns/10ps
module telegram_start_sync_detector_tb;
  import tsd_pkg::*;
  logic        sys_clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, dco_fine_offset;
  logic        hreadyout, hresp, chip_valid, chip_data, sym_sync;
  logic        frame_sync_event, found_pattern_b, pll_reset;
  logic        dco_phase_adjust, manchester_phase, phase_realigned, irq;
  int          n_fail, num_checks, n_sync, n_pll, n_dco, n_align;

  typedef struct {
    logic        set;
    logic [7:0]  mode, lena, lenb, gap;
    logic [31:0] s;
    int          n;
    logic [3:0]  e;
  } row_type;

  // Expectation: {sync count, pattern b (x = not checked), pll, dco}
  row_type rows [15] = '{
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 32'h000000b4, 16, 4'b1000},
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 32'h000000b5, 16, 4'b0000},
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 32'h0000004b, 16, 4'b1100},
    '{0, 8'h09, 8'h08, 8'h08, 8'h00, 32'h000000b5, 16, 4'b1000},
    '{0, 8'h03, 8'h08, 8'h08, 8'h00, 32'h0000004b, 16, 4'b1100},
    '{0, 8'h03, 8'h08, 8'h08, 8'h00, 32'h000000b4, 16, 4'b1000},
    '{0, 8'h00, 8'h08, 8'h08, 8'h00, 32'h0000b44b, 24, 4'b1x00},
    '{0, 8'h00, 8'h08, 8'h08, 8'h00, 32'h0000b400, 24, 4'b0x00},
    '{0, 8'h00, 8'h08, 8'h00, 8'h00, 32'h000000b4, 16, 4'b1x00},
    '{0, 8'h01, 8'h10, 8'h08, 8'h00, 32'h00003cb4, 32, 4'b1000},
    '{0, 8'h01, 8'h1f, 8'h08, 8'h00, 32'h00003cb4, 32, 4'b1000},
    '{0, 8'h01, 8'h08, 8'h1f, 8'h00, 32'h0000004b, 32, 4'b1100},
    '{1, 8'h02, 8'h08, 8'h08, 8'h13, 32'h0002d24b, 26, 4'b1x01},
    '{1, 8'h82, 8'h08, 8'h08, 8'h13, 32'h0002d24b, 26, 4'b1x10},
    '{1, 8'h02, 8'h08, 8'h08, 8'h03, 32'h0000b44b, 24, 4'b1x01}
  };

  telegram_start_sync_detector i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chip_valid(chip_valid), .chip_data(chip_data),
    .sym_sync(sym_sync), .frame_sync_event(frame_sync_event),
    .found_pattern_b(found_pattern_b), .pll_reset(pll_reset),
    .dco_phase_adjust(dco_phase_adjust),
    .dco_fine_offset(dco_fine_offset),
    .manchester_phase(manchester_phase),
    .phase_realigned(phase_realigned), .irq(irq)
  );

  chip_source i_src (
    .sys_clk(sys_clk), .chip_valid(chip_valid), .chip_data(chip_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Event counters, cleared before each stream
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (frame_sync_event === 1'b1) n_sync++;
    if (pll_reset === 1'b1) n_pll++;
    if (dco_phase_adjust === 1'b1) n_dco++;
    if (phase_realigned === 1'b1) n_align++;
  end

  // ------------------------------------------------------------
  // Compare, bus and configuration tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // Register index to byte address; hready is sampled before moving on
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cfg(input logic set, input logic [7:0] m, la, lb, g);
    logic [7:0] v [8];
    v = '{m, la, lb, g, 8'hb4, 8'h3c, 8'h4b, 8'h00};
    for (int i = 0; i < 8; i++)
      ahb(1'b1, (set ? IDX_MODE2 : IDX_MODE1) + i[7:0], {24'h0, v[i]});
    ahb(1'b1, IDX_CTRL, {30'h0, 1'b1, set});
    n_sync  = 0;
    n_pll   = 0;
    n_dco   = 0;
    n_align = 0;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A full run needs about 1400 cycles
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sym_sync = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk1(hreadyout, 1'b1);
    chk1(irq, 1'b0);
    for (int k = 0; k < 15; k++) begin
      cfg(rows[k].set, rows[k].mode, rows[k].lena, rows[k].lenb, rows[k].gap);
      i_src.send(rows[k].s, rows[k].n, 0);
      repeat (8) @(posedge sys_clk);
      chk32(n_sync, {31'h0, rows[k].e[3]});
      if (rows[k].e[2] !== 1'bx) chk1(found_pattern_b, rows[k].e[2]);
      chk32(n_pll, {31'h0, rows[k].e[1]});
      chk32(n_dco, {31'h0, rows[k].e[0]});
      chk1(hresp, 1'b0);
      $display("row %0d done", k);
    end
    chk32({29'h0, dco_fine_offset}, 32'h3);
    ahb(1'b0, IDX_PAL1, 32'h0);
    chk32(rd, 32'h0);
    ahb(1'b0, 8'hff, 32'h0);
    chk32(rd, 32'h0);
    $display("register reads done");
    // Status is sticky; irq follows only unmasked bits
    ahb(1'b0, IDX_STATUS, 32'h0);
    chk1(rd[EV_SYNC], 1'b1);
    chk1(irq, 1'b0);
    ahb(1'b1, IDX_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk1(irq, 1'b1);
    ahb(1'b1, IDX_STATUS, 32'h7);
    repeat (2) @(posedge sys_clk);
    chk1(irq, 1'b0);
    $display("interrupt test done");
    for (int r = 0; r < 2; r++) begin
      cfg(1'b0, r ? 8'h05 : 8'h01, 8'h08, 8'h08, 8'h00);
      i_src.send(32'h000000b4, 16, 0);
      i_src.send(32'h00000004, 3, 2);
      repeat (8) @(posedge sys_clk);
      chk1(n_align != 0, r[0]);
      chk1(manchester_phase, !r[0]);
    end
    $display("realign test done");
    cfg(1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge sys_clk);
    sym_sync <= 1'b1;
    @(posedge sys_clk);
    sym_sync <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk32(n_sync, 32'h1);
    $display("symbol sync test done");
    // Mid-run reset must drop latched offset and sticky status
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk32({29'h0, dco_fine_offset}, 32'h0);
    chk1(irq, 1'b0);
    ahb(1'b0, IDX_STATUS, 32'h0);
    chk32(rd, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule // telegram_start_sync_detector_tb
